// ### hw/mcu_exec_consts.svh
`ifndef MCU_EXEC_CONSTS_SVH
`define MCU_EXEC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CMD       8'h00
`define OFS_OPERAND   8'h04
`define OFS_IMM       8'h08
`define OFS_TARGET    8'h0C
`define OFS_WORK      8'h10
`define OFS_FLAGS     8'h14
`define OFS_PC        8'h18
`define OFS_STATUS    8'h1C
`define OFS_WDOG      8'h20
`define OFS_MEM_DATA  8'h24
`define OFS_STACK_TOP 8'h28

// ----------------------------------------------------------------------
// Command register fields and instruction codes
// ----------------------------------------------------------------------
`define CMD_OP_LSB    0
`define CMD_OP_MSB    3
`define CMD_BIT_LSB   4
`define CMD_BIT_MSB   6

`define OP_NOP        4'h0
`define OP_ADC        4'h1
`define OP_ADC_TO_MEM 4'h2
`define OP_ADD_MEM    4'h3
`define OP_ADD_IMM    4'h4
`define OP_ADD_TO_MEM 4'h5
`define OP_AND_MEM    4'h6
`define OP_AND_IMM    4'h7
`define OP_AND_TO_MEM 4'h8
`define OP_CALL       4'h9
`define OP_CLR_MEM    4'hA
`define OP_CLR_BIT    4'hB
`define OP_CLR_WDOG   4'hC
`define OP_INV_MEM    4'hD
`define OP_INV_WORK   4'hE
`define OP_BCD        4'hF

// ----------------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------------
`define FLG_C         0
`define FLG_HC        1
`define FLG_Z         2
`define FLG_SX        3
`define FLG_SGN       4
`define FLG_TMO       5
`define FLG_PD        6

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define STS_BUSY      0
`define STS_DEPTH_LSB 8
`define STS_DEPTH_MSB 11

// ----------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------
`define RST_BYTE      8'h00
`define RST_PC        13'h0000
`define RST_WDOG      16'h0000
`define PC_STEP       13'h0001
`define BCD_LIMIT     4'h9
`define BCD_FIX       4'h6
`define WDOG_LIMIT    65535

`endif

// ### hw/mcu_exec_pkg.sv
`default_nettype none
package mcu_exec_pkg;
  // Execution sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_CALL_PUSH,
    ST_CALL_LOAD
  } exec_state_t;

  // Result of one 8-bit addition with all its carries
  typedef struct packed {
    logic [7:0] sum;
    logic carry;
    logic half;
    logic overflow;
  } add_res_t;
endpackage
`default_nettype wire

// ### hw/data_store.sv
`default_nettype none
// 256 x 8 data memory; read data come out of a register
module data_store (
  input wire logic pclk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem [0:255];

  // Write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, so a written byte shows one cycle later
  always_ff @(posedge pclk) begin
    rdata_q <= mem[raddr];
  end
endmodule // data_store
`default_nettype wire

// ### hw/return_stack.sv
`default_nettype none
// Eight-level return stack; a ninth push overwrites the oldest entry
module return_stack (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [12:0] push_data,
  output logic [12:0] top_q,
  output logic [3:0] depth_q
);
  logic [12:0] slot [0:7];
  logic [2:0] ptr_q;

  // Storage; no reset needed, unread until pushed
  always_ff @(posedge pclk) begin
    if (push) begin
      slot[ptr_q] <= push_data;
    end
  end

  // Circular pointer; wraps after eight pushes so the oldest entry is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 3'h0;
      top_q <= 13'h0000;
    end else if (push) begin
      ptr_q <= ptr_q + 3'h1;
      top_q <= push_data;
    end
  end

  // Depth saturates at eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= 4'h0;
    end else if (push && depth_q != 4'h8) begin
      depth_q <= depth_q + 4'h1;
    end
  end
endmodule // return_stack
`default_nettype wire

// ### hw/mcu_exec.sv
// Our own choices: the placing of the registers and the APB slave port.
`include "mcu_exec_consts.svh"
`default_nettype none
module mcu_exec #(
  parameter int unsigned WDOG_LIMIT = `WDOG_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import mcu_exec_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Full 8-bit add with carry in, half carry and signed overflow
  function automatic add_res_t add8(input logic [7:0] a, input logic [7:0] b,
                                    input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    add_res_t r;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.sum = full[7:0];
    r.carry = full[8];
    r.half = low[4];
    r.overflow = (a[7] == b[7]) && (full[7] != a[7]);
    return r;
  endfunction

  // Register offset match on a word-aligned address
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    return (addr[31:8] == 24'h00_0000) && (addr[7:0] == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  exec_state_t state_q;
  logic [3:0] op_q;
  logic [2:0] bit_q;
  logic [7:0] operand_q;
  logic [7:0] imm_q;
  logic [12:0] target_q;
  logic [7:0] work_q;
  logic [12:0] pc_q;
  logic [15:0] wdog_q;
  logic [7:0] fetch_q;
  logic flag_c_q, flag_hc_q, flag_z_q, flag_sx_q, flag_sgn_q, flag_tmo_q, flag_pd_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  logic [7:0] mem_rdata;
  logic [12:0] stack_top;
  logic [3:0] stack_depth;

  // APB access phase completing at this edge
  logic access_done, wr_done, busy;
  assign access_done = psel && penable && pready_q;
  assign wr_done = access_done && pwrite;
  assign busy = (state_q != ST_IDLE);

  logic cmd_start;
  assign cmd_start = wr_done && hit(paddr, `OFS_CMD) && !busy;

  // ----------------------------------------------------------------------
  // Datapath for the instruction in the execute cycle
  // ----------------------------------------------------------------------
  add_res_t add_r;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] res;
  logic res_to_work, res_to_mem, upd_arith, upd_zero, upd_bcd_c;
  logic bcd_carry;
  logic [8:0] bcd_val;

  // Operand and carry select for the adder
  always_comb begin
    add_b = (op_q == `OP_ADD_IMM) ? imm_q : mem_rdata;
    add_cin = ((op_q == `OP_ADC) || (op_q == `OP_ADC_TO_MEM)) ? flag_c_q : 1'b0;
  end

  assign add_r = add8(work_q, add_b, add_cin);

  // Decimal adjust of the work register; high nibble follows the low fix
  always_comb begin
    logic [8:0] tmp;
    tmp = {1'b0, work_q};
    if ((work_q[3:0] > `BCD_LIMIT) || flag_hc_q) begin
      tmp = tmp + {5'h00, `BCD_FIX};
    end
    if ((tmp[7:4] > `BCD_LIMIT) || tmp[8] || flag_c_q) begin
      tmp = tmp + {1'b0, `BCD_FIX, 4'h0};
    end
    bcd_val = tmp;
    bcd_carry = tmp[8];
  end

  // Result, destination and flag groups per instruction
  always_comb begin
    res = add_r.sum;
    res_to_work = 1'b0;
    res_to_mem = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    upd_bcd_c = 1'b0;
    case (op_q)
      `OP_ADC, `OP_ADD_MEM, `OP_ADD_IMM: begin
        res_to_work = 1'b1;
        upd_arith = 1'b1;
      end
      `OP_ADC_TO_MEM, `OP_ADD_TO_MEM: begin
        res_to_mem = 1'b1;
        upd_arith = 1'b1;
      end
      `OP_AND_MEM: begin
        res = work_q & mem_rdata;
        res_to_work = 1'b1;
        upd_zero = 1'b1;
      end
      `OP_AND_IMM: begin
        res = work_q & imm_q;
        res_to_work = 1'b1;
        upd_zero = 1'b1;
      end
      `OP_AND_TO_MEM: begin
        res = work_q & mem_rdata;
        res_to_mem = 1'b1;
        upd_zero = 1'b1;
      end
      `OP_CLR_MEM: begin
        res = `RST_BYTE;
        res_to_mem = 1'b1;
      end
      `OP_CLR_BIT: begin
        res = mem_rdata & ~(8'h01 << bit_q);
        res_to_mem = 1'b1;
      end
      `OP_INV_MEM: begin
        res = ~mem_rdata;
        res_to_mem = 1'b1;
        upd_zero = 1'b1;
      end
      `OP_INV_WORK: begin
        res = ~mem_rdata;
        res_to_work = 1'b1;
        upd_zero = 1'b1;
      end
      `OP_BCD: begin
        res = bcd_val[7:0];
        res_to_mem = 1'b1;
        upd_bcd_c = 1'b1;
      end
      default: begin
        res = add_r.sum;
      end
    endcase
  end

  logic exec_now;
  assign exec_now = (state_q == ST_EXEC);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Every command but a call reads its memory operand first so the registered
  // memory output is settled before the execute cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_start) begin
            if (pwdata[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_CALL) begin
              state_q <= ST_CALL_PUSH;
            end else begin
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: state_q <= ST_EXEC;
        ST_EXEC: state_q <= ST_IDLE;
        ST_CALL_PUSH: state_q <= ST_CALL_LOAD;
        ST_CALL_LOAD: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Command capture; writes while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= `OP_NOP;
      bit_q <= 3'h0;
    end else if (cmd_start) begin
      op_q <= pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
      bit_q <= pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
    end
  end

  // Operand registers, frozen while an instruction runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_q <= `RST_BYTE;
      imm_q <= `RST_BYTE;
      target_q <= `RST_PC;
    end else if (wr_done && !busy) begin
      if (hit(paddr, `OFS_OPERAND)) operand_q <= pwdata[7:0];
      if (hit(paddr, `OFS_IMM)) imm_q <= pwdata[7:0];
      if (hit(paddr, `OFS_TARGET)) target_q <= pwdata[12:0];
    end
  end

  // Work register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_q <= `RST_BYTE;
    end else if (exec_now && res_to_work) begin
      work_q <= res;
    end else if (wr_done && !busy && hit(paddr, `OFS_WORK)) begin
      work_q <= pwdata[7:0];
    end
  end

  // Program counter; a call loads the target in its second cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `RST_PC;
    end else if (state_q == ST_CALL_LOAD) begin
      pc_q <= target_q;
    end else if (exec_now) begin
      pc_q <= pc_q + `PC_STEP;
    end
  end

  // Memory operand as last read, visible through the data window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_q <= `RST_BYTE;
    end else if (exec_now) begin
      fetch_q <= res_to_mem ? res : mem_rdata;
    end else if (!busy) begin
      fetch_q <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  // Arithmetic flags; a call leaves them all alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_c_q <= 1'b0;
      flag_hc_q <= 1'b0;
      flag_sx_q <= 1'b0;
      flag_sgn_q <= 1'b0;
    end else if (exec_now && upd_arith) begin
      flag_c_q <= add_r.carry;
      flag_hc_q <= add_r.half;
      flag_sx_q <= add_r.overflow;
      flag_sgn_q <= add_r.overflow ^ add_r.sum[7];
    end else if (exec_now && upd_bcd_c) begin
      flag_c_q <= flag_c_q | bcd_carry;
    end else if (wr_done && !busy && hit(paddr, `OFS_FLAGS)) begin
      flag_c_q <= pwdata[`FLG_C];
      flag_hc_q <= pwdata[`FLG_HC];
      flag_sx_q <= pwdata[`FLG_SX];
      flag_sgn_q <= pwdata[`FLG_SGN];
    end
  end

  // Zero flag follows the 8-bit result of every affecting instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_z_q <= 1'b0;
    end else if (exec_now && (upd_arith || upd_zero)) begin
      flag_z_q <= (res == 8'h00);
    end else if (wr_done && !busy && hit(paddr, `OFS_FLAGS)) begin
      flag_z_q <= pwdata[`FLG_Z];
    end
  end

  logic wdog_clr, wdog_expire;
  assign wdog_clr = exec_now && (op_q == `OP_CLR_WDOG);
  assign wdog_expire = (32'(wdog_q) >= WDOG_LIMIT);

  // Watchdog counter; wraps on expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_q <= `RST_WDOG;
    end else if (wdog_clr || wdog_expire) begin
      wdog_q <= `RST_WDOG;
    end else begin
      wdog_q <= wdog_q + 16'h0001;
    end
  end

  // Timeout and powerdown; a watchdog clear wins over expiry, expiry wins over a flags write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_tmo_q <= 1'b0;
      flag_pd_q <= 1'b0;
    end else if (wdog_clr) begin
      flag_tmo_q <= 1'b0;
      flag_pd_q <= 1'b0;
    end else if (wr_done && hit(paddr, `OFS_FLAGS)) begin
      flag_tmo_q <= pwdata[`FLG_TMO] | wdog_expire;
      flag_pd_q <= pwdata[`FLG_PD];
    end else if (wdog_expire) begin
      flag_tmo_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Memory and stack
  // ----------------------------------------------------------------------
  logic mem_we;
  logic [7:0] mem_wdata;

  // Execution owns the write port while busy, software otherwise
  always_comb begin
    mem_we = 1'b0;
    mem_wdata = res;
    if (exec_now && res_to_mem) begin
      mem_we = 1'b1;
    end else if (wr_done && !busy && hit(paddr, `OFS_MEM_DATA)) begin
      mem_we = 1'b1;
      mem_wdata = pwdata[7:0];
    end
  end

  data_store u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(operand_q),
    .wdata(mem_wdata),
    .raddr(operand_q),
    .rdata_q(mem_rdata)
  );

  return_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(state_q == ST_CALL_PUSH),
    .push_data(pc_q + `PC_STEP),
    .top_q(stack_top),
    .depth_q(stack_depth)
  );

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;

  // Read mux and address decode for the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(paddr, `OFS_CMD)) rd_word = {24'h00_0000, 1'b0, bit_q, op_q};
    else if (hit(paddr, `OFS_OPERAND)) rd_word = {24'h00_0000, operand_q};
    else if (hit(paddr, `OFS_IMM)) rd_word = {24'h00_0000, imm_q};
    else if (hit(paddr, `OFS_TARGET)) rd_word = {19'h0_0000, target_q};
    else if (hit(paddr, `OFS_WORK)) rd_word = {24'h00_0000, work_q};
    else if (hit(paddr, `OFS_FLAGS)) begin
      rd_word = {25'h000_0000, flag_pd_q, flag_tmo_q, flag_sgn_q, flag_sx_q,
                 flag_z_q, flag_hc_q, flag_c_q};
    end
    else if (hit(paddr, `OFS_PC)) rd_word = {19'h0_0000, pc_q};
    else if (hit(paddr, `OFS_STATUS)) rd_word = {20'h0_0000, stack_depth, 7'h00, busy};
    else if (hit(paddr, `OFS_WDOG)) rd_word = {16'h0000, wdog_q};
    else if (hit(paddr, `OFS_MEM_DATA)) rd_word = {24'h00_0000, fetch_q};
    else if (hit(paddr, `OFS_STACK_TOP)) rd_word = {19'h0_0000, stack_top};
    else rd_ok = 1'b0;
  end

  // No wait state: answer is registered in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !rd_ok;
      prdata_q <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule // mcu_exec
`default_nettype wire

// ### dv/mcu_exec_assertions.sv
`default_nettype none
module mcu_exec_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus answer timing and decode
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // Aligned word offsets up to the stack-top register decode
  assign mapped = (paddr[31:6] == 26'h000_0000) && (paddr[1:0] == 2'b00)
                  && (paddr[5:0] <= 6'h28);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("answer outside an access phase");
  ready_single_a: assert property (pready |=> !pready)
    else $error("answer held past one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  rdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  err_rdata_a: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  // Main traffic kinds
  cover property (psel && penable && pready && pwrite);
  cover property (psel && penable && pready && !pwrite);
  cover property (pslverr);
endmodule // mcu_exec_checker
`default_nettype wire

// ### dv/mcu_exec_bench.sv
`include "mcu_exec_consts.svh"
`default_nettype none
module mcu_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, berr, b1, b0;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] w_rd, m_rd, f_rd;
  int err_count, tests_run;
  int cyc = 0;
  mcu_exec #(.WDOG_LIMIT(600)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Leaves psel up so the next transfer can follow at once
  task automatic xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    berr = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Loads operands, runs one instruction, reads back the state
  task automatic ex(input logic [3:0] op, input logic [2:0] b, input logic [7:0] mem,
                    input logic [7:0] wk, input logic [7:0] imm, input logic [7:0] fl);
    xf(1'b1, `OFS_OPERAND, 32'h0000_0033);
    xf(1'b1, `OFS_MEM_DATA, {24'h00_0000, mem});
    xf(1'b1, `OFS_WORK, {24'h00_0000, wk});
    xf(1'b1, `OFS_IMM, {24'h00_0000, imm});
    xf(1'b1, `OFS_FLAGS, {24'h00_0000, fl});
    xf(1'b1, `OFS_CMD, {25'h000_0000, b, op});
    xf(1'b0, `OFS_STATUS, 32'h0000_0000);
    b1 = rd[0];
    xf(1'b0, `OFS_STATUS, 32'h0000_0000);
    b0 = rd[0];
    xf(1'b0, `OFS_WORK, 32'h0000_0000);
    w_rd = rd[7:0];
    xf(1'b0, `OFS_FLAGS, 32'h0000_0000);
    f_rd = rd[7:0] & 8'h1F;
    xf(1'b0, `OFS_MEM_DATA, 32'h0000_0000);
    m_rd = rd[7:0];
    idle();
  endtask
  // Result in the top byte, flags sign, excess, zero, half carry, carry low
  function automatic logic [15:0] add_exp(input logic [7:0] a, input logic [7:0] b,
                                          input logic c);
    logic [8:0] s;
    logic h, v;
    s = {1'b0, a} + {1'b0, b} + {8'h00, c};
    h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c}) > 5'h0F;
    v = (a[7] == b[7]) && (s[7] != a[7]);
    return {s[7:0], 3'b000, v ^ s[7], v, s[7:0] == 8'h00, h, s[8]};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bus();
    xf(1'b0, `OFS_FLAGS, 32'h0000_0000);
    chk("flags rst", rd, 32'h0000_0000);
    xf(1'b1, `OFS_PC, 32'h0000_0555);
    xf(1'b0, `OFS_PC, 32'h0000_0000);
    chk("pc ro", rd, 32'h0000_0000);
    xf(1'b0, 8'h2C, 32'h0000_0000);
    chk("unmapped err", berr, 1'b1);
    chk("unmapped data", rd, 32'h0000_0000);
    idle();
  endtask
  task automatic t_add();
    logic [7:0] va [4] = '{8'h7F, 8'hFF, 8'h80, 8'h38};
    logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h80, 8'h47};
    logic [3:0] ops [5] = '{`OP_ADC, `OP_ADC_TO_MEM, `OP_ADD_MEM, `OP_ADD_IMM,
                            `OP_ADD_TO_MEM};
    logic [15:0] e;
    logic md, im;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 5; k++) begin
        md = (k == 1) || (k == 4);
        im = (k == 3);
        // Carry flag preset on odd vectors; only the carry forms may use it
        ex(ops[k], 3'd0, im ? 8'hC3 : vb[i], va[i], im ? vb[i] : 8'h3C, {7'h00, i[0]});
        e = add_exp(va[i], vb[i], (k < 2) && i[0]);
        chk("add work", w_rd, md ? va[i] : e[15:8]);
        chk("add mem", m_rd, md ? e[15:8] : (im ? 8'hC3 : vb[i]));
        chk("add flags", f_rd, {3'b000, e[4:0]});
      end
    end
  endtask
  task automatic t_logic();
    logic [3:0] ops [3] = '{`OP_AND_MEM, `OP_AND_IMM, `OP_AND_TO_MEM};
    logic [7:0] wk, ot, r, fl;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 2; i++) begin
        wk = i[0] ? 8'hF0 : 8'h3C;
        ot = i[0] ? 8'h0F : 8'h36;
        fl = i[0] ? 8'h1B : 8'h04;
        r = wk & ot;
        ex(ops[k], 3'd0, k == 1 ? 8'h99 : ot, wk, k == 1 ? ot : 8'h66, fl);
        chk("and work", w_rd, k == 2 ? wk : r);
        chk("and mem", m_rd, k == 2 ? r : (k == 1 ? 8'h99 : ot));
        chk("and flags", f_rd, (fl & 8'h1B) | (r == 8'h00 ? 8'h04 : 8'h00));
      end
    end
  endtask
  task automatic t_clr();
    ex(`OP_CLR_MEM, 3'd5, 8'hA5, 8'h11, 8'h22, 8'h1F);
    chk("clr mem", m_rd, 8'h00);
    chk("clr flags", f_rd, 8'h1F);
    for (int b = 0; b < 8; b++) begin
      ex(`OP_CLR_BIT, b[2:0], 8'hFF, 8'h11, 8'h22, 8'h0A);
      chk("bit mem", m_rd, 8'(~(8'h01 << b)));
      chk("bit flags", f_rd, 8'h0A);
    end
  endtask
  task automatic t_cpl();
    logic [7:0] m, fl, ez;
    for (int i = 0; i < 4; i++) begin
      m = i[0] ? 8'hFF : 8'h5A;
      fl = i[0] ? 8'h1B : 8'h1F;
      ez = (fl & 8'h1B) | (m == 8'hFF ? 8'h04 : 8'h00);
      ex(i[1] ? `OP_INV_WORK : `OP_INV_MEM, 3'd0, m, 8'h77, 8'h00, fl);
      chk("cpl work", w_rd, i[1] ? 8'(~m) : 8'h77);
      chk("cpl mem", m_rd, i[1] ? m : 8'(~m));
      chk("cpl flags", f_rd, ez);
    end
  endtask
  task automatic t_bcd();
    logic [7:0] wk [5] = '{8'h3A, 8'h21, 8'hA5, 8'h99, 8'h45};
    logic [7:0] fl [5] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h18};
    logic [7:0] em [5] = '{8'h40, 8'h27, 8'h05, 8'hF9, 8'h45};
    logic ec [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      ex(`OP_BCD, 3'd0, 8'h5C, wk[i], 8'h00, fl[i]);
      chk("bcd mem", m_rd, em[i]);
      chk("bcd work", w_rd, wk[i]);
      chk("bcd flags", f_rd, fl[i] | {7'h00, ec[i]});
    end
  endtask
  task automatic t_call();
    logic [31:0] p0;
    xf(1'b0, `OFS_PC, 32'h0000_0000);
    p0 = rd;
    xf(1'b1, `OFS_TARGET, 32'h0000_1ABC);
    ex(`OP_CALL, 3'd0, 8'h5C, 8'h66, 8'h00, 8'h1F);
    chk("call busy", {b1, b0}, 2'b10);
    chk("call flags", f_rd, 8'h1F);
    xf(1'b0, `OFS_PC, 32'h0000_0000);
    chk("call pc", rd, 32'h0000_1ABC);
    xf(1'b0, `OFS_STACK_TOP, 32'h0000_0000);
    chk("call push", rd, p0 + 32'h0000_0001);
    xf(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("call depth", rd[11:8], 4'h1);
    idle();
  endtask
  task automatic t_wdog();
    xf(1'b1, `OFS_FLAGS, 32'h0000_0040);
    rd = 32'h0000_0000;
    // Bounded wait for the counter to expire once
    for (int n = 0; n < 400 && rd[5] !== 1'b1; n++) begin
      xf(1'b0, `OFS_FLAGS, 32'h0000_0000);
    end
    chk("wdog expired", rd[6:5], 2'b11);
    ex(`OP_CLR_WDOG, 3'd0, 8'h00, 8'h00, 8'h00, 8'h60);
    xf(1'b0, `OFS_FLAGS, 32'h0000_0000);
    chk("wdog flags", rd[6:5], 2'b00);
    xf(1'b0, `OFS_WDOG, 32'h0000_0000);
    chk("wdog count", rd < 32'h0000_0020, 1'b1);
    idle();
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always #2 pclk = ~pclk;
  // Cuts a hung handshake short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    err_count = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_add();
    t_logic();
    t_clr();
    t_cpl();
    t_bcd();
    t_call();
    t_wdog();
    conclude();
  end
endmodule // mcu_exec_bench
bind mcu_exec mcu_exec_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
